// ==== logic/pwm_pkg.sv ====
// Package: register map, field layout, reset values and types of the PWM unit
package pwm_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_CCP_CONTROL = 4'h0;
  localparam logic [3:0] OFS_CCP_VALUE_LOW = 4'h1;
  localparam logic [3:0] OFS_CCP_VALUE_HIGH = 4'h2;
  localparam logic [3:0] OFS_CORE_INT_CTRL = 4'h3;
  localparam logic [3:0] OFS_PERIPH_IRQ_EN = 4'h4;
  localparam logic [3:0] OFS_PERIPH_IRQ_FLAGS = 4'h5;
  localparam logic [3:0] OFS_PORT_DIRECTION = 4'h6;
  localparam logic [3:0] OFS_PERIOD_LIMIT = 4'h7;
  localparam logic [3:0] OFS_PERIOD_TIMER_CTRL = 4'h8;
  localparam logic [3:0] OFS_PERIOD_TIMER_COUNT = 4'h9;
  localparam logic [7:0] RST_CCP_CONTROL = 8'h00;
  localparam logic [7:0] RST_CORE_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ = 8'h00;
  localparam logic [7:0] RST_PORT_DIRECTION = 8'h3f;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
  localparam logic [7:0] RST_PERIOD_TIMER_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIOD_TIMER_COUNT = 8'h00;
  localparam logic [7:0] MASK_CCP_CONTROL = 8'h3f;
  localparam logic [7:0] MASK_PERIPH_IRQ = 8'hef;
  localparam logic [7:0] MASK_PORT_DIRECTION = 8'h3f;
  localparam logic [7:0] MASK_PERIOD_TIMER_CTRL = 8'h7f;
  localparam int DUTY_LOW_LSB = 4;
  localparam int MODE_PWM_HI = 3;
  localparam int MODE_PWM_LO = 2;
  localparam int TMR_ON_BIT = 2;
  localparam int PERIOD_MATCH_BIT = 1;
  localparam int PWM_PIN_BIT = 2;
  localparam int GIE_BIT = 7;
  localparam int PEIE_BIT = 6;
  localparam logic [1:0] PRESCALE_1 = 2'b00;
  localparam logic [1:0] PRESCALE_4 = 2'b01;

  typedef struct packed {
    logic [7:0] ccp_control;
    logic [7:0] ccp_value_low;
    logic [7:0] ccp_value_high;
    logic [1:0] duty_latch_low;
    logic [7:0] core_interrupt_control;
    logic [7:0] peripheral_irq_enable;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] port_direction;
    logic [7:0] period_limit;
    logic [7:0] period_timer_control;
    logic [7:0] period_timer_count;
    logic [5:0] prescale_count;
    logic pwm_level;
    logic [7:0] read_data;
    logic read_valid;
  } pwm_state_s;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_s;
endpackage

// ==== logic/pwm_prescaler.sv ====
// Period timer prescaler: selects the increment tick and time base phase bits
`timescale 1ns/1ns
module pwm_prescaler (
  input wire logic [1:0] i_prescale,
  input wire logic [5:0] i_count,
  input wire logic i_run,
  output logic o_tick,
  output logic [1:0] o_phase
);
  // Four clocks per timer step, times 1, 4 or 16
  always_comb begin
    o_tick = 1'b0;
    o_phase = i_count[1:0];
    if (i_prescale == pwm_pkg::PRESCALE_1) begin
      o_tick = i_run && (i_count[1:0] == 2'h3);
      o_phase = i_count[1:0];
    end else if (i_prescale == pwm_pkg::PRESCALE_4) begin
      o_tick = i_run && (i_count[3:0] == 4'hf);
      o_phase = i_count[3:2];
    end else begin
      o_tick = i_run && (i_count[5:0] == 6'h3f);
      o_phase = i_count[5:4];
    end
  end
endmodule

// ==== logic/pwm_unit.sv ====
// PWM unit with period timer, double-buffered duty and Avalon-MM register slave
`timescale 1ns/1ns
// Summary of operation
// - PWM timing counts system clock cycles only
// - Reset sets all port pins to input
// - Reset returns all unit registers to defaults
// - Unimplemented bits read back as zero
// - After match: clear timer, set pin if new duty is nonzero, latch duty
// - Pin clears when time base equals latched duty
// - Duty is value low byte plus two bits
// - Sleep freezes timer, state and pin level
module pwm_unit (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sleep,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_pwm_out_pin,
  output logic o_pwm_out_pin_oe,
  output logic [5:0] o_port_output_enable_n,
  output logic o_irq
);
  pwm_pkg::pwm_state_s st_r;
  pwm_pkg::pwm_state_s st_nxt;
  pwm_pkg::avmm_req_s req;
  logic pwm_mode;
  logic tick;
  logic [1:0] phase_nxt;
  logic [5:0] prescale_inc;
  logic timer_run;
  logic [9:0] time_base;
  logic [9:0] duty_latched;
  logic [7:0] wdata;
  logic wr_en;
  logic period_match;
  logic sync0_r;
  logic sleep_r;

  assign req.address = i_avs_address;
  assign req.read = i_avs_read;
  assign req.write = i_avs_write;
  assign req.writedata = i_avs_writedata;
  assign req.byteenable = i_avs_byteenable;

  // Sleep request from outside the clock domain
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync0_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      sync0_r <= i_sleep;
      sleep_r <= sync0_r;
    end
  end

  assign pwm_mode = st_r.ccp_control[pwm_pkg::MODE_PWM_HI] && st_r.ccp_control[pwm_pkg::MODE_PWM_LO];
  assign wdata = req.writedata[7:0];
  assign wr_en = req.write && req.byteenable[0];

  assign timer_run = st_r.period_timer_control[pwm_pkg::TMR_ON_BIT] && !sleep_r;
  assign prescale_inc = st_r.prescale_count + 6'h01;

  pwm_prescaler u_prescaler (
    .i_prescale(st_r.period_timer_control[1:0]),
    .i_count(st_r.prescale_count),
    .i_run(timer_run),
    .o_tick(tick),
    .o_phase()
  );

  // Phase bits after this edge
  pwm_prescaler u_prescaler_nxt (
    .i_prescale(st_r.period_timer_control[1:0]),
    .i_count(prescale_inc),
    .i_run(1'b0),
    .o_tick(),
    .o_phase(phase_nxt)
  );

  // Next-cycle time base, so the pin falls exactly duty steps after it rose
  assign time_base = {tick ? st_r.period_timer_count + 8'h01 : st_r.period_timer_count, phase_nxt};
  assign duty_latched = {st_r.ccp_value_high, st_r.duty_latch_low};
  assign period_match = (st_r.period_timer_count == st_r.period_limit);

  always_comb begin
    st_nxt = st_r;
    st_nxt.read_valid = 1'b0;
    // Timer advances on system clock cycles; frozen in sleep
    if (timer_run) begin
      st_nxt.prescale_count = prescale_inc;
    end
    if (tick) begin
      if (period_match) begin
        st_nxt.period_timer_count = 8'h00;
        st_nxt.peripheral_irq_flags[pwm_pkg::PERIOD_MATCH_BIT] = 1'b1;
        if (pwm_mode) begin
          st_nxt.ccp_value_high = st_r.ccp_value_low;
          st_nxt.duty_latch_low = st_r.ccp_control[pwm_pkg::DUTY_LOW_LSB +: 2];
          st_nxt.pwm_level = ({st_r.ccp_value_low, st_r.ccp_control[pwm_pkg::DUTY_LOW_LSB +: 2]} != 10'h000);
        end
      end else begin
        st_nxt.period_timer_count = st_r.period_timer_count + 8'h01;
      end
    end
    if (pwm_mode && timer_run) begin
      if (time_base == duty_latched && !(tick && period_match)) begin
        st_nxt.pwm_level = 1'b0;
      end
    end
    if (!pwm_mode) begin
      st_nxt.pwm_level = 1'b0;
    end
    if (wr_en) begin
      unique case (req.address)
        pwm_pkg::OFS_CCP_CONTROL: st_nxt.ccp_control = wdata & pwm_pkg::MASK_CCP_CONTROL;
        pwm_pkg::OFS_CCP_VALUE_LOW: st_nxt.ccp_value_low = wdata;
        pwm_pkg::OFS_CCP_VALUE_HIGH: begin
          if (!pwm_mode) begin
            st_nxt.ccp_value_high = wdata;
          end
        end
        pwm_pkg::OFS_CORE_INT_CTRL: st_nxt.core_interrupt_control = wdata;
        pwm_pkg::OFS_PERIPH_IRQ_EN: st_nxt.peripheral_irq_enable = wdata & pwm_pkg::MASK_PERIPH_IRQ;
        pwm_pkg::OFS_PERIPH_IRQ_FLAGS: begin
          // Write one clears; a same-cycle set wins
          st_nxt.peripheral_irq_flags = st_nxt.peripheral_irq_flags & ~(wdata & pwm_pkg::MASK_PERIPH_IRQ);
          if (tick && period_match) begin
            st_nxt.peripheral_irq_flags[pwm_pkg::PERIOD_MATCH_BIT] = 1'b1;
          end
        end
        pwm_pkg::OFS_PORT_DIRECTION: st_nxt.port_direction = wdata & pwm_pkg::MASK_PORT_DIRECTION;
        pwm_pkg::OFS_PERIOD_LIMIT: st_nxt.period_limit = wdata;
        pwm_pkg::OFS_PERIOD_TIMER_CTRL: st_nxt.period_timer_control = wdata & pwm_pkg::MASK_PERIOD_TIMER_CTRL;
        pwm_pkg::OFS_PERIOD_TIMER_COUNT: begin
          st_nxt.period_timer_count = wdata;
          st_nxt.prescale_count = 6'h00;
        end
        default: begin
        end
      endcase
    end
    if (req.read && !st_r.read_valid) begin
      st_nxt.read_valid = 1'b1;
      unique case (req.address)
        pwm_pkg::OFS_CCP_CONTROL: st_nxt.read_data = st_r.ccp_control;
        pwm_pkg::OFS_CCP_VALUE_LOW: st_nxt.read_data = st_r.ccp_value_low;
        pwm_pkg::OFS_CCP_VALUE_HIGH: st_nxt.read_data = st_r.ccp_value_high;
        pwm_pkg::OFS_CORE_INT_CTRL: st_nxt.read_data = st_r.core_interrupt_control;
        pwm_pkg::OFS_PERIPH_IRQ_EN: st_nxt.read_data = st_r.peripheral_irq_enable;
        pwm_pkg::OFS_PERIPH_IRQ_FLAGS: st_nxt.read_data = st_r.peripheral_irq_flags;
        pwm_pkg::OFS_PORT_DIRECTION: st_nxt.read_data = st_r.port_direction;
        pwm_pkg::OFS_PERIOD_LIMIT: st_nxt.read_data = st_r.period_limit;
        pwm_pkg::OFS_PERIOD_TIMER_CTRL: st_nxt.read_data = st_r.period_timer_control;
        pwm_pkg::OFS_PERIOD_TIMER_COUNT: st_nxt.read_data = st_r.period_timer_count;
        default: st_nxt.read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r.ccp_control <= pwm_pkg::RST_CCP_CONTROL;
      st_r.ccp_value_low <= 8'h00;
      st_r.ccp_value_high <= 8'h00;
      st_r.duty_latch_low <= 2'h0;
      st_r.core_interrupt_control <= pwm_pkg::RST_CORE_INT_CTRL;
      st_r.peripheral_irq_enable <= pwm_pkg::RST_PERIPH_IRQ;
      st_r.peripheral_irq_flags <= pwm_pkg::RST_PERIPH_IRQ;
      st_r.port_direction <= pwm_pkg::RST_PORT_DIRECTION;
      st_r.period_limit <= pwm_pkg::RST_PERIOD_LIMIT;
      st_r.period_timer_control <= pwm_pkg::RST_PERIOD_TIMER_CTRL;
      st_r.period_timer_count <= pwm_pkg::RST_PERIOD_TIMER_COUNT;
      st_r.prescale_count <= 6'h00;
      st_r.pwm_level <= 1'b0;
      st_r.read_data <= 8'h00;
      st_r.read_valid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_avs_waitrequest = i_avs_read && !st_r.read_valid;
  assign o_avs_readdata = {24'h000000, st_r.read_data};
  assign o_pwm_out_pin = st_r.pwm_level;
  // Driver released while direction bit is input or unit not in PWM
  assign o_pwm_out_pin_oe = !st_r.port_direction[pwm_pkg::PWM_PIN_BIT] && pwm_mode;
  assign o_port_output_enable_n = st_r.port_direction[5:0];
  assign o_irq = st_r.peripheral_irq_flags[pwm_pkg::PERIOD_MATCH_BIT]
    && st_r.peripheral_irq_enable[pwm_pkg::PERIOD_MATCH_BIT]
    && st_r.core_interrupt_control[pwm_pkg::PEIE_BIT]
    && st_r.core_interrupt_control[pwm_pkg::GIE_BIT];
endmodule

// ==== sim/pwm_unit_monitor.sv ====
// Port assertions for the PWM unit
`timescale 1ns/1ns
module pwm_unit_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sleep,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic o_pwm_out_pin,
  input wire logic o_pwm_out_pin_oe,
  input wire logic [5:0] o_port_output_enable_n,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic rd_done = i_avs_read && !o_avs_waitrequest;
  property p_rst_dir; $fell(i_sys_rst) |-> o_port_output_enable_n == 6'h3f && !o_pwm_out_pin_oe; endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("port not input after reset");
  property p_rd_wait; $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read answer timing wrong");
  property p_wr_nowait; i_avs_write |-> !o_avs_waitrequest; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_hi; rd_done |-> o_avs_readdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_unmapped; rd_done && i_avs_address > 4'h9 |-> o_avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_stand; !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata); endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
  property p_oe_dir; o_pwm_out_pin_oe |-> !o_port_output_enable_n[2]; endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin driven while input");
  property p_sleep; i_sleep [*5] |=> $stable(o_pwm_out_pin) && $stable(o_pwm_out_pin_oe); endproperty
  a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
  c_rd: cover property (rd_done);
  c_pin: cover property ($rose(o_pwm_out_pin));
  c_irq: cover property ($rose(o_irq));
endmodule
bind pwm_unit pwm_unit_monitor pwm_unit_monitor_i (.i_clk, .i_sys_rst, .i_sleep, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_pwm_out_pin, .o_pwm_out_pin_oe, .o_port_output_enable_n,
  .o_irq);

// ==== sim/pwm_load.sv ====
// Load on the PWM pin: measures one period and its high time in clocks
`timescale 1ns/1ns
module pwm_load (
  input wire logic i_clk,
  input wire logic i_pin,
  input wire logic i_oe,
  output logic o_done = 1'b0,
  output logic [23:0] o_meas
);
  logic [11:0] cnt = 12'h0, hi = 12'h0;
  logic [1:0] st = 2'h0;
  logic last = 1'b0;
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    last <= i_pin;
    cnt <= cnt + 12'h1;
    hi <= hi + 12'(i_pin);
    if (!i_oe) begin
      st <= 2'h0;
    end else if (i_pin && !last) begin
      // First rise arms, second reports once
      cnt <= 12'h1;
      hi <= 12'h1;
      st <= st + 2'(st < 2'h2);
      o_done <= st == 2'h1;
      o_meas <= {cnt, hi};
    end
  end
endmodule

// ==== sim/pwm_unit_tb_top.sv ====
// Bench for the PWM unit: bus driver, reply monitor and scenarios
`timescale 1ns/1ns
module pwm_unit_tb_top;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_sleep = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic o_avs_waitrequest, o_pwm_out_pin, o_pwm_out_pin_oe, o_irq, ld_done;
  logic [5:0] o_port_output_enable_n;
  logic [23:0] ld_meas, mt, pw_q[$];
  logic [11:0] rt, rd_q[$];
  logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'hff, 8'h00, 8'h00, 8'h00};
  logic [7:0] mm [9] = '{8'h3f, 8'h00, 8'hff, 8'h00, 8'hef, 8'h00, 8'h3f, 8'h00, 8'h7f};
  int failures = 0, tests_run = 0, pr, d, sc, n;
  always #25 i_clk = ~i_clk;
  pwm_unit pwm_unit_i (.i_clk, .i_sys_rst, .i_sleep, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_pwm_out_pin, .o_pwm_out_pin_oe,
    .o_port_output_enable_n, .o_irq);
  pwm_load pwm_load_i (.i_clk, .i_pin(o_pwm_out_pin), .i_oe(o_pwm_out_pin_oe), .o_done(ld_done), .o_meas(ld_meas));
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic guard(inout int k);
    k++;
    if (k > 9000) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] v);
    int k;
    k = 0;
    if (!w) rd_q.push_back({a, v});
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= {24'h0, v};
    do begin
      @(posedge i_clk);
      guard(k);
    end while (o_avs_waitrequest !== 1'b0);
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      rt = rd_q.pop_front();
      chk($sformatf("reg %h", rt[11:8]), {24'h0, rt[7:0]}, o_avs_readdata);
    end
    if (ld_done === 1'b1 && pw_q.size() > 0) begin
      mt = pw_q.pop_front();
      chk("period and high", {8'h0, mt}, {8'h0, ld_meas});
    end
  end
  initial begin
    void'($urandom(32'hd9c8));
    for (int r = 0; r < 2; r++) begin
      i_sys_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      chk("port dir", 32'h3f, {26'h0, o_port_output_enable_n});
      for (int i = 0; i < 11; i++) bus(4'(i), 1'b0, rv[i]);
      $display("reset test %0d done", r);
      if (r == 0) begin
        for (int i = 0; i < 9; i += 2) begin
          bus(4'(i), 1'b1, 8'hff);
          bus(4'(i), 1'b0, mm[i]);
          bus(4'(i), 1'b1, rv[i]);
        end
        bus(4'h3, 1'b1, 8'hc0);
        for (int p = 0; p < 3; p++) begin
          sc = 1 << (2 * p);
          pr = 2 + $urandom % 4;
          d = 1 + $urandom % (4 * pr + 3);
          bus(4'h4, 1'b1, 8'h02);
          bus(4'h6, 1'b1, 8'h3f);
          bus(4'h8, 1'b1, 8'h00);
          bus(4'h9, 1'b1, 8'h00);
          bus(4'h7, 1'b1, 8'(pr));
          bus(4'h0, 1'b1, {2'b00, 2'(d), 2'b11, 2'($urandom)});
          bus(4'h1, 1'b1, 8'(d >> 2));
          bus(4'h5, 1'b1, 8'h02);
          bus(4'h8, 1'b1, {5'h0, 1'b1, 2'(p)});
          n = 0;
          while (o_irq !== 1'b1) begin
            @(posedge i_clk);
            guard(n);
          end
          bus(4'h4, 1'b1, 8'h00);
          bus(4'h2, 1'b1, 8'hff);
          chk("irq masked", 32'h0, {31'h0, o_irq});
          bus(4'h2, 1'b0, 8'(d >> 2));
          bus(4'h4, 1'b1, 8'h02);
          bus(4'h5, 1'b0, 8'h02);
          chk("irq unmasked", 32'h1, {31'h0, o_irq});
          pw_q.push_back({12'(4 * (pr + 1) * sc), 12'(d * sc)});
          bus(4'h6, 1'b1, 8'h3b);
          n = 0;
          while (pw_q.size() > 0) begin
            @(posedge i_clk);
            guard(n);
          end
          i_sleep <= 1'b1;
          repeat (9) @(posedge i_clk);
          i_sleep <= 1'b0;
          bus(4'h8, 1'b1, 8'h00);
          bus(4'h5, 1'b1, 8'h02);
          bus(4'h5, 1'b0, 8'h00);
          $display("pwm test %0d done", p);
        end
      end
    end
    tally_and_finish();
  end
endmodule
